// File: logic/hp_mix_pkg.sv
// Constants for the left headphone mixer routing register bank.
// Assumes word-wide AHB-Lite access with one register per aligned word.
package hp_mix_pkg;

  // ---------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int NUM_SOURCES = 6;
  localparam logic [7:0] IDX_LEFT_LINE2_TO_LEFT_HP = 8'h2d;
  localparam logic [7:0] IDX_LEFT_AMP_TO_LEFT_HP = 8'h2e;
  localparam logic [7:0] IDX_LEFT_DAC_TO_LEFT_HP = 8'h2f;
  localparam logic [7:0] IDX_RIGHT_LINE2_TO_LEFT_HP = 8'h30;
  localparam logic [7:0] IDX_RIGHT_AMP_TO_LEFT_HP = 8'h31;
  localparam logic [7:0] IDX_RIGHT_DAC_TO_LEFT_HP = 8'h32;
  localparam int BYTE_ADDR_SHIFT = 2;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int ROUTE_BIT = 7;
  localparam int CODE_W = 7;
  localparam logic [REG_W-1:0] GAIN_REG_RESET = 8'h00;
  localparam logic [CODE_W-1:0] MUTE_FIRST_CODE = 7'h76;
  localparam int GAIN_W = 10;
  localparam logic [GAIN_W-1:0] MUTE_TENTHS = 10'h3ff;

  // ---------------------------------------------------------------
  // Bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] HRDATA_UNMAPPED = 32'h0000_0000;

endpackage : hp_mix_pkg

// File: logic/hp_gain_rom.sv
// Attenuation lookup for one mixer source: code in, gain in 0.1 dB steps out.
// Assumes one clock; results appear one cycle after the code changes.
`timescale 1ns/1ps
module hp_gain_rom
  import hp_mix_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [hp_mix_pkg::CODE_W-1:0] code,
  output logic [hp_mix_pkg::GAIN_W-1:0] atten_tenths,
  output logic muted
);
  import hp_mix_pkg::*;

  // ---------------------------------------------------------------
  // Gain table
  // ---------------------------------------------------------------
  function automatic logic [GAIN_W-1:0] gain_lookup(input logic [CODE_W-1:0] c);
    logic [GAIN_W-1:0] cw;
    cw = GAIN_W'(c);
    if (c <= 7'd36)
      gain_lookup = GAIN_W'(cw * 10'd5);
    else if (c <= 7'd59)
      gain_lookup = GAIN_W'(10'd186 + (cw - 10'd37) * 10'd5);
    else if (c <= 7'd65)
      gain_lookup = GAIN_W'(10'd301 + (cw - 10'd60) * 10'd5);
    else if (c <= 7'd70)
      gain_lookup = GAIN_W'(10'd331 + (cw - 10'd66) * 10'd5);
    else if (c >= 7'd76 && c <= 7'd86)
      gain_lookup = GAIN_W'(10'd382 + (cw - 10'd76) * 10'd5);
    else
    begin
      unique case (c)
        7'd71: gain_lookup = 10'd357;
        7'd72: gain_lookup = 10'd361;
        7'd73: gain_lookup = 10'd367;
        7'd74: gain_lookup = 10'd371;
        7'd75: gain_lookup = 10'd377;
        7'd87: gain_lookup = 10'd438;
        7'd88: gain_lookup = 10'd443;
        7'd89: gain_lookup = 10'd448;
        7'd90: gain_lookup = 10'd452;
        7'd91: gain_lookup = 10'd458;
        7'd92: gain_lookup = 10'd462;
        7'd93: gain_lookup = 10'd467;
        7'd94: gain_lookup = 10'd474;
        7'd95: gain_lookup = 10'd479;
        7'd96: gain_lookup = 10'd482;
        7'd97: gain_lookup = 10'd487;
        7'd98: gain_lookup = 10'd493;
        7'd99: gain_lookup = 10'd500;
        7'd100: gain_lookup = 10'd503;
        7'd101: gain_lookup = 10'd510;
        7'd102: gain_lookup = 10'd514;
        7'd103: gain_lookup = 10'd518;
        7'd104: gain_lookup = 10'd522;
        7'd105: gain_lookup = 10'd527;
        7'd106: gain_lookup = 10'd537;
        7'd107: gain_lookup = 10'd542;
        7'd108: gain_lookup = 10'd553;
        7'd109: gain_lookup = 10'd567;
        7'd110: gain_lookup = 10'd583;
        7'd111: gain_lookup = 10'd602;
        7'd112: gain_lookup = 10'd627;
        7'd113: gain_lookup = 10'd643;
        7'd114: gain_lookup = 10'd662;
        7'd115: gain_lookup = 10'd687;
        7'd116: gain_lookup = 10'd722;
        7'd117: gain_lookup = 10'd783;
        default: gain_lookup = MUTE_TENTHS;
      endcase
    end
  endfunction : gain_lookup

  // ---------------------------------------------------------------
  // Registered read
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      atten_tenths <= '0;
      muted <= 1'b0;
    end
    else
    begin
      atten_tenths <= gain_lookup(code);
      muted <= (code >= MUTE_FIRST_CODE);
    end
  end

endmodule : hp_gain_rom

// File: logic/left_hp_mixer_regs.sv
// Routing and attenuation registers for the left headphone driver mixer.
// Assumes an AHB-Lite master on hclk; slave never inserts wait states.
//
// Overview of operation
// - Left second line input reaches the mixer only while register 0x2d bit 7 set.
// - Left input amplifier reaches the mixer only while register 0x2e bit 7 set.
// - Left converter path one reaches the mixer only while 0x2f bit 7 set.
// - Right second line input reaches the mixer only while 0x30 bit 7 set.
// - Right input amplifier reaches the mixer only while 0x31 bit 7 set.
// - Right converter path one reaches the mixer only while 0x32 bit 7 set.
// - Bits 6 to 0 of each register hold a writable attenuation code.
// - Code maps through a fixed gain table; codes 118 to 127 mute.
// - Reset clears every routing bit and attenuation code to zero.
// - Every source gets its own identical attenuation control.
`timescale 1ns/1ps
module left_hp_mixer_regs
  import hp_mix_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [hp_mix_pkg::NUM_SOURCES-1:0] route_en,
  output logic [hp_mix_pkg::NUM_SOURCES*hp_mix_pkg::CODE_W-1:0] atten_code,
  output logic [hp_mix_pkg::NUM_SOURCES*hp_mix_pkg::GAIN_W-1:0] atten_tenths,
  output logic [hp_mix_pkg::NUM_SOURCES-1:0] source_muted
);
  import hp_mix_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Returns {hit, slot}; slot 0..5 follows the register index order.
  function automatic logic [3:0] decode_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> BYTE_ADDR_SHIFT;
    decode_slot = 4'h0;
    if (a[BYTE_ADDR_SHIFT-1:0] == '0 && idx >= ADDR_W'(IDX_LEFT_LINE2_TO_LEFT_HP)
        && idx <= ADDR_W'(IDX_RIGHT_DAC_TO_LEFT_HP))
      decode_slot = {1'b1, 3'(idx - ADDR_W'(IDX_LEFT_LINE2_TO_LEFT_HP))};
  endfunction : decode_slot

  logic [REG_W-1:0] gain_reg [NUM_SOURCES];
  logic accept;
  logic [3:0] addr_dec;
  logic wr_pend;
  logic wr_hit;
  logic [2:0] wr_slot;

  assign accept = hsel && hready && (htrans[1] != HTRANS_IDLE[1]);
  assign addr_dec = decode_slot(haddr);
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // ---------------------------------------------------------------
  // Write data phase
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_hit <= 1'b0;
      wr_slot <= 3'h0;
    end
    else if (hready)
    begin
      wr_pend <= accept && hwrite;
      wr_hit <= addr_dec[3];
      wr_slot <= addr_dec[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_SOURCES; i++)
        gain_reg[i] <= GAIN_REG_RESET;
    end
    else if (wr_pend && wr_hit)
    begin
      gain_reg[wr_slot] <= hwdata[REG_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Forward a write still in its data phase so back-to-back read sees it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= HRDATA_UNMAPPED;
    else if (accept && !hwrite)
    begin
      if (!addr_dec[3])
        hrdata <= HRDATA_UNMAPPED;
      else if (wr_pend && wr_hit && wr_slot == addr_dec[2:0])
        hrdata <= {24'h000000, hwdata[REG_W-1:0]};
      else
        hrdata <= {24'h000000, gain_reg[addr_dec[2:0]]};
    end
  end

  // ---------------------------------------------------------------
  // Per-source routing and attenuation
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_SOURCES; i++)
  begin : g_src
    // Source routing gates
    assign route_en[i] = gain_reg[i][ROUTE_BIT];
    assign atten_code[i*CODE_W +: CODE_W] = gain_reg[i][CODE_W-1:0];

    hp_gain_rom u_rom (
      .hclk(hclk),
      .hresetn(hresetn),
      .code(gain_reg[i][CODE_W-1:0]),
      .atten_tenths(atten_tenths[i*GAIN_W +: GAIN_W]),
      .muted(source_muted[i])
    );
  end

endmodule : left_hp_mixer_regs

// File: verif/left_hp_mixer_asserts.sv
// Checker for the left headphone mixer register bank.
// Sees only the top module's ports; the bind follows the module.
`timescale 1ns/1ps
module left_hp_mixer_asserts
  import hp_mix_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [5:0] route_en,
  input wire logic [41:0] atten_code,
  input wire logic [59:0] atten_tenths,
  input wire logic [5:0] source_muted
);
  import hp_mix_pkg::*;
  logic acc;
  logic map;
  logic wr_acc;
  logic [2:0] slot;
  logic [ADDR_W-1:0] off;
  logic [5:0] mute_exp;
  assign off = haddr - ADDR_W'(8'hb4);
  assign slot = off[4:2];
  assign acc = hsel && hready && htrans[1];
  assign map = off < ADDR_W'(24) && off[1:0] == 2'h0;
  assign wr_acc = acc && hwrite && map;
  always_comb
    for (int i = 0; i < 6; i++)
      mute_exp[i] = atten_code[i*7+:7] >= MUTE_FIRST_CODE;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Write address phase, then its data phase
  sequence s_wr;
    wr_acc ##1 1'b1;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_wr_route: assert property (
    s_wr |=> route_en[$past(slot, 2)] == $past(hwdata[7]))
    else $error("routing bit not written");
  a_wr_code: assert property (
    s_wr |=> atten_code[$past(slot, 2)*7+:7] == $past(hwdata[6:0]))
    else $error("code not written");
  a_route_cause: assert property ($changed(route_en) |-> $past(wr_acc, 2))
    else $error("routing changed without write");
  a_rd_upper: assert property (acc && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  a_rd_unmapped: assert property (acc && !hwrite && !map |=> hrdata == HRDATA_UNMAPPED)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!(acc && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without read");
  a_mute_flag: assert property (source_muted == $past(mute_exp))
    else $error("mute flag wrong");
  a_tenths_mute: assert property (source_muted[0] |-> atten_tenths[9:0] == MUTE_TENTHS)
    else $error("muted gain wrong");
  a_tenths_zero: assert property ($past(atten_code[6:0]) == 7'h0 |-> atten_tenths[9:0] == 10'h0)
    else $error("zero code gain wrong");
endmodule : left_hp_mixer_asserts

bind left_hp_mixer_regs left_hp_mixer_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .route_en(route_en),
  .atten_code(atten_code), .atten_tenths(atten_tenths), .source_muted(source_muted));

// File: verif/tb.sv
// Self-checking bench for the left headphone mixer register bank.
// Drives AHB-Lite itself; the checker is bound to the design.
`timescale 1ns/1ps
module tb;
  import hp_mix_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h0b65;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [2:0] hsize = 3'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [5:0] route_en;
  logic [5:0] source_muted;
  logic [41:0] atten_code;
  logic [59:0] atten_tenths;
  logic [7:0] shadow [7] = '{default: 8'h0};
  logic [6:0] codes [10] = '{7'h00, 7'h06, 7'h24, 7'h25, 7'h47,
    7'h4c, 7'h57, 7'h75, 7'h76, 7'h7f};
  int err_total = 0;
  int compares = 0;
  int k;
  left_hp_mixer_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .route_en(route_en),
    .atten_code(atten_code), .atten_tenths(atten_tenths), .source_muted(source_muted));
  initial
    forever #50 hclk = ~hclk;
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  // Gain in tenths of a dB for the codes under test
  function automatic logic [9:0] gain_exp(input logic [6:0] c);
    case (c)
      7'h00: return 10'h000;
      7'h06: return 10'h01e;
      7'h24: return 10'h0b4;
      7'h25: return 10'h0ba;
      7'h47: return 10'h165;
      7'h4c: return 10'h17e;
      7'h57: return 10'h1b6;
      7'h75: return 10'h30f;
      default: return MUTE_TENTHS;
    endcase
  endfunction : gain_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // All six registers plus one unmapped word
  task automatic check_all();
    for (int s = 0; s < 7; s++)
    begin
      xfer(0, 32'hb4 + 4 * s, 0);
      chk(rd, {24'h0, shadow[s]});
    end
  endtask : check_all
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    #500000;
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check_all();
    $display("reset test done");
    for (int i = 0; i < 40; i++)
    begin
      lfsr = next_rand(lfsr);
      k = lfsr[10:8] % 6;
      shadow[k] = lfsr[7:0];
      xfer(1, 32'hb4 + 4 * k, lfsr);
      xfer(0, 32'hb4 + 4 * k, 0);
      chk(rd, {24'h0, shadow[k]});
      chk(32'(route_en[k]), 32'(shadow[k][7]));
      chk(32'(atten_code[k*7+:7]), 32'(shadow[k][6:0]));
      chk(32'(source_muted[k]), 32'(shadow[k][6:0] >= MUTE_FIRST_CODE));
    end
    xfer(1, 32'hcc, 32'hff);
    xfer(1, 32'hb0, 32'hff);
    check_all();
    $display("random test done");
    for (int j = 0; j < 10; j++)
    begin
      k = j % 6;
      shadow[k] = {1'b1, codes[j]};
      xfer(1, 32'hb4 + 4 * k, {24'h0, shadow[k]});
      @(negedge hclk);
      @(negedge hclk);
      chk(32'(atten_tenths[k*10+:10]), 32'(gain_exp(codes[j])));
      chk(32'(source_muted[k]), 32'(codes[j] >= MUTE_FIRST_CODE));
    end
    check_all();
    $display("gain test done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    shadow = '{default: 8'h0};
    check_all();
    chk(32'(route_en), 32'h0);
    chk(32'(atten_code != '0), 32'h0);
    chk(32'(source_muted), 32'h0);
    $display("second reset test done");
    finish_test();
  end
endmodule : tb
